// ---- src/ddci_pkg.sv ----
`default_nettype none
package ddci_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS     = 40;
  localparam int WR_OFF_NS  = 1000;
  localparam int WR_OFF_CYC = WR_OFF_NS / CLK_NS;
  localparam int DESEL_MS   = 20;
  localparam int DESEL_CYC  = DESEL_MS * 1000000 / CLK_NS;
  localparam int SYNC_LAT   = 3;
  // ----------------------------------------------------------------
  // command and parameter byte
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_ATTN_CTRL = 8'h40;
  localparam logic [7:0] CMD_WR_CTRL   = 8'h41;
  localparam int         DIR_BIT       = 6;
  localparam int         PARAM_BIT     = 7;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       port_en;
    logic       dir_out;
    logic       strobe;
    logic       cmd_req;
    logic       par_req;
    logic       read_gate;
    logic       write_gate;
    logic       am_ctrl;
    logic [7:0] bus;
  } ddci_pins_s;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_CMD_ACK = 5'h02,
    ST_PAR_WT  = 5'h04,
    ST_EXEC    = 5'h08,
    ST_PAR_ACK = 5'h10
  } ddci_state_e;
endpackage
`default_nettype wire

// ---- src/ddci_device.sv ----
// How it works
// R01: with port enable inactive the device ignores the whole protocol
// R02: enable loss: write off within 1 us, deselect within 20 ms, stay off
// R03: enable returning active sets attention after the initial state
// R04: reset, enable or reinit command: deselect, clear command parameters
// R05: initial state clears resettable errors, sets initial bit, causes re-raise
// R06: direction active means host to device; all lines active low
// R07: strobe selects with direction active, polls attention otherwise
// R08: strobe edge selects on own radial line active, deselects otherwise
// R09: strobe with all bus lines inactive deselects every device
// R10: attention poll drives attention onto own radial bus line
// R11: host holds command request until acknowledge
// R12: host holds parameter request until acknowledge, byte as per direction
// R13: acknowledge answers selection and both daisy-chain requests
// R14: busy only while commands cannot be taken, raised before acknowledge
// R15: busy falling sets attention
// R16: command request during busy waits for busy to drop
// R17: wired-OR attention driven when set and enabled, selected or not
// R18: only service clear or fault clear removes attention
// R19: one index pulse per revolution from the selected device
// R20: sector pulses follow ticks, suppressed when coinciding with index
// R21: one address mark detection per mark control assertion
// R22: write needs earlier write permission; mark written with mark control
// R23: every daisy-chain exchange is command byte then parameter byte
// R24: command bit 6 against direction; mismatch sets attention, bus error
// R25: immediate command acknowledged after action; failure sets attention first
// R26: all asynchronous pins pass two flip-flops before edge detection
`timescale 1ns/1ps
`default_nettype none
module ddci_device
  import ddci_pkg::*;
#(
  parameter int UNIT      = 0,
  parameter int DESEL_MAX = ddci_pkg::DESEL_CYC
)(
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  input  wire ddci_pkg::ddci_pins_s pins_n_i,
  input  wire logic                 busy_cause_i,
  input  wire logic                 err_cause_i,
  input  wire logic                 done_i,
  input  wire logic                 fail_i,
  input  wire logic [7:0]           status_i,
  input  wire logic                 svc_clear_i,
  input  wire logic                 fault_clear_i,
  input  wire logic                 reinit_i,
  input  wire logic                 index_tick_i,
  input  wire logic                 sector_tick_i,
  input  wire logic                 am_found_i,
  output logic [7:0]                ctl_bus_n_o,
  output logic [7:0]                ctl_bus_oe_n_o,
  output logic                      ack_n_o,
  output logic                      busy_n_o,
  output logic                      attn_n_o,
  output logic                      attn_oe_n_o,
  output logic                      index_n_o,
  output logic                      sector_n_o,
  output logic                      write_en_o,
  output logic                      am_write_o,
  output logic                      exec_o,
  output logic [7:0]                cmd_byte_o,
  output logic [7:0]                param_byte_o,
  output logic                      selected_o,
  output logic                      init_state_o,
  output logic                      bus_err_o,
  output logic                      fault_o
);
  import ddci_pkg::*;

  initial
  begin
    if (UNIT < 0 || UNIT > 7)
      $error("unit number out of range");
    if (SYNC_LAT > WR_OFF_CYC || SYNC_LAT > DESEL_MAX)
      $error("enable loss cannot be met");
  end

  // ----------------------------------------------------------------
  // input synchroniser, inverted to active high
  // ----------------------------------------------------------------
  ddci_pins_s  sync1, in, prev;
  ddci_state_e state, next_state;
  logic        attn, attn_dis, write_perm, sel_ack, am_done;
  logic        busy_prev, par_in_ok;
  logic        next_sel, next_attn, next_attn_dis, next_write_perm;
  logic        next_sel_ack, next_am_done, next_par_in_ok, next_exec;
  logic        next_init, next_bus_err, next_fault;
  logic [7:0]  next_cmd, next_param, next_drive;
  logic        pe, pe_rise, sel_edge, poll, init, busy_fall;
  logic        mismatch, am_pulse, next_ack;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    pe        = in.port_en;                             // R01
    pe_rise   = pe && !prev.port_en;
    sel_edge  = pe && in.dir_out && in.strobe && !prev.strobe; // R07
    poll      = pe && !in.dir_out && in.strobe;         // R07
    init      = pe_rise || reinit_i;                    // R04
    busy_fall = busy_prev && !busy_cause_i;
    mismatch  = 1'b0;
    next_exec = 1'b0;
    next_state      = state;
    next_cmd        = cmd_byte_o;
    next_param      = param_byte_o;
    next_par_in_ok  = par_in_ok;
    next_attn_dis   = attn_dis;
    next_write_perm = write_perm;
    next_attn       = attn;
    next_sel        = selected_o;
    next_sel_ack    = sel_ack;

    if (sel_edge)
    begin
      next_sel     = in.bus[UNIT];                      // R08 R09
      next_sel_ack = in.bus[UNIT];                      // R13
    end
    if (!in.strobe || !pe)
      next_sel_ack = 1'b0;
    if (!pe || init)
      next_sel = 1'b0;                                  // R02 R04

    // two-byte exchange
    case (state)
      ST_IDLE:
        if (selected_o && in.cmd_req && in.dir_out && !busy_cause_i) // R16
        begin
          next_cmd   = in.bus;                          // R23
          next_state = ST_CMD_ACK;
        end
      ST_CMD_ACK:
        if (!in.cmd_req)
          next_state = ST_PAR_WT;                       // R11
      ST_PAR_WT:
        if (in.cmd_req)
          next_state = ST_IDLE;
        else if (in.par_req)
        begin
          if (in.dir_out != cmd_byte_o[DIR_BIT])
          begin
            mismatch       = 1'b1;                      // R24
            next_par_in_ok = 1'b0;
            next_state     = ST_PAR_ACK;
          end
          else
          begin
            next_par_in_ok = !in.dir_out;
            if (in.dir_out)
              next_param = in.bus;                      // R12
            next_exec  = 1'b1;
            next_state = ST_EXEC;
          end
        end
      ST_EXEC:
        if (done_i)
        begin
          if (par_in_ok)
            next_param = status_i;
          next_state = ST_PAR_ACK;                      // R25
        end
      ST_PAR_ACK:
        if (!in.par_req)
          next_state = ST_IDLE;                         // R12
      default:
        next_state = ST_IDLE;
    endcase
    if (!selected_o || !pe)
      next_state = ST_IDLE;

    // parameters of the two commands held here
    if (exec_o && !par_in_ok && cmd_byte_o == CMD_ATTN_CTRL)
      next_attn_dis = param_byte_o[PARAM_BIT];
    if (exec_o && !par_in_ok && cmd_byte_o == CMD_WR_CTRL)
      next_write_perm = param_byte_o[PARAM_BIT];        // R22
    if (init)
    begin
      next_attn_dis   = 1'b0;                           // R04
      next_write_perm = 1'b0;
    end

    // attention: clear first so that any set wins
    if (svc_clear_i)
      next_attn = 1'b0;                                 // R18
    if (fault_clear_i && !err_cause_i)
      next_attn = 1'b0;                                 // R18
    if (pe_rise || busy_fall || mismatch || err_cause_i
        || (state == ST_EXEC && done_i && fail_i))
      next_attn = 1'b1;                                 // R03 R15 R24 R25

    // error flags
    next_bus_err = bus_err_o;
    next_fault   = fault_o;
    next_init    = init_state_o;
    if (fault_clear_i)
    begin
      next_bus_err = 1'b0;
      next_fault   = 1'b0;
      next_init    = 1'b0;
    end
    if (init)
    begin
      next_bus_err = 1'b0;                              // R05
      next_fault   = 1'b0;
      next_init    = 1'b1;
    end
    if (mismatch)
      next_bus_err = 1'b1;                              // R24
    if (err_cause_i)
      next_fault = 1'b1;                                // R05

    // address mark detection, one per mark control assertion
    am_pulse = selected_o && in.read_gate && in.am_ctrl
               && am_found_i && !am_done;               // R21
    next_am_done = in.am_ctrl && (am_done || am_pulse);

    // ack lags the state by a cycle so attention is already set
    next_ack = sel_ack || state == ST_CMD_ACK
               || state == ST_PAR_ACK;                  // R13 R25
    next_drive = 8'h00;
    if (poll && attn)
      next_drive[UNIT] = 1'b1;                          // R10
    else if (pe && state == ST_PAR_ACK && par_in_ok && !in.dir_out)
      next_drive = param_byte_o;                        // R12
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      sync1          <= '0;
      in             <= '0;
      prev           <= '0;
      state          <= ST_IDLE;
      attn           <= 1'b0;
      attn_dis       <= 1'b0;
      write_perm     <= 1'b0;
      sel_ack        <= 1'b0;
      am_done        <= 1'b0;
      busy_prev      <= 1'b0;
      par_in_ok      <= 1'b0;
      ctl_bus_n_o    <= 8'h00;
      ctl_bus_oe_n_o <= 8'hff;
      ack_n_o        <= 1'b1;
      busy_n_o       <= 1'b1;
      attn_n_o       <= 1'b1;
      attn_oe_n_o    <= 1'b1;
      index_n_o      <= 1'b1;
      sector_n_o     <= 1'b1;
      write_en_o     <= 1'b0;
      am_write_o     <= 1'b0;
      exec_o         <= 1'b0;
      cmd_byte_o     <= 8'h00;
      param_byte_o   <= 8'h00;
      selected_o     <= 1'b0;
      init_state_o   <= 1'b1;
      bus_err_o      <= 1'b0;
      fault_o        <= 1'b0;
    end
    else
    begin
      sync1          <= ddci_pins_s'(~pins_n_i);        // R06 R26
      in             <= sync1;                          // R26
      prev           <= in;
      state          <= next_state;
      attn           <= next_attn;
      attn_dis       <= next_attn_dis;
      write_perm     <= next_write_perm;
      sel_ack        <= next_sel_ack;
      am_done        <= next_am_done;
      busy_prev      <= busy_cause_i;
      par_in_ok      <= next_par_in_ok;
      ctl_bus_n_o    <= 8'h00;
      ctl_bus_oe_n_o <= ~next_drive;
      ack_n_o        <= !(next_ack && pe);
      busy_n_o       <= !(selected_o && busy_cause_i);  // R14
      attn_n_o       <= !(attn && !attn_dis && pe);     // R17
      attn_oe_n_o    <= !(attn && !attn_dis && pe);     // R17
      index_n_o      <= !(selected_o && index_tick_i);  // R19
      sector_n_o     <= !(selected_o && ((sector_tick_i && !index_tick_i)
                          || am_pulse));                // R20 R21
      write_en_o     <= selected_o && pe && in.write_gate
                        && write_perm;                  // R02 R22
      am_write_o     <= selected_o && pe && in.write_gate
                        && write_perm && in.am_ctrl;    // R22
      exec_o         <= next_exec;
      cmd_byte_o     <= next_cmd;
      param_byte_o   <= next_param;
      selected_o     <= next_sel;
      init_state_o   <= next_init;
      bus_err_o      <= next_bus_err;
      fault_o        <= next_fault;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_off_quiet;
    !in.port_en |=> ctl_bus_oe_n_o == 8'hff && ack_n_o;
  endproperty
  a_off_quiet: assert property (p_off_quiet) // R01
    else $error("device answered with port enable off");
  property p_off_desel;
    !in.port_en |=> !selected_o ##1 !write_en_o;
  endproperty
  a_off_desel: assert property (p_off_desel) // R02
    else $error("still selected or writing after enable loss");
  property p_select;
    sel_edge && in.bus[UNIT] && !init |=> selected_o ##2 !ack_n_o;
  endproperty
  a_select: assert property (p_select) // R08
    else $error("selection or its acknowledge missing");
  property p_all_off;
    sel_edge && in.bus == 8'h00 |=> !selected_o;
  endproperty
  a_all_off: assert property (p_all_off) // R09
    else $error("device kept selection with empty bus");
  property p_busy_hold;
    state == ST_IDLE && busy_cause_i |=> state == ST_IDLE;
  endproperty
  a_busy_hold: assert property (p_busy_hold) // R16
    else $error("command taken while busy");
  property p_busy_attn;
    busy_prev && !busy_cause_i |=> attn;
  endproperty
  a_busy_attn: assert property (p_busy_attn) // R15
    else $error("busy drop did not set attention");
  property p_attn_out;
    attn && !attn_dis && in.port_en |=> !attn_oe_n_o;
  endproperty
  a_attn_out: assert property (p_attn_out) // R17
    else $error("attention not driven");
  property p_am_once;
    am_pulse |=> !am_pulse [*2];
  endproperty
  a_am_once: assert property (p_am_once) // R21
    else $error("second mark detection in one assertion");
  property p_sec_sup;
    index_tick_i && !am_pulse |=> sector_n_o;
  endproperty
  a_sec_sup: assert property (p_sec_sup) // R20
    else $error("sector pulse not suppressed at index");
  property p_mismatch;
    mismatch |=> bus_err_o && attn ##1 !ack_n_o;
  endproperty
  a_mismatch: assert property (p_mismatch) // R24
    else $error("direction mismatch not flagged");
  property p_fail_first;
    state == ST_EXEC && done_i && fail_i |=> attn && ack_n_o;
  endproperty
  a_fail_first: assert property (p_fail_first) // R25
    else $error("acknowledge before failure attention");

  c_select: cover property (sel_edge && in.bus[UNIT]);
  c_cmd:    cover property (state == ST_CMD_ACK ##[1:20] state == ST_EXEC);
  c_am:     cover property (am_pulse);
  c_poll:   cover property (poll && attn);
endmodule
`default_nettype wire

// ---- testbench/ddci_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddci_host_model (
  input  wire logic                clk_sys_i,
  input  wire logic                ack_n_i,
  input  wire logic [7:0]          ctl_bus_n_i,
  input  wire logic [7:0]          ctl_bus_oe_n_i,
  output var ddci_pkg::ddci_pins_s pins_n_o
);
  import ddci_pkg::*;
  ddci_pins_s drv;
  int         lag;
  // ------------------------------------------------------------
  // wired bus
  // ------------------------------------------------------------
  // released lines float high through the terminators
  always_comb
  begin
    pins_n_o     = drv;
    pins_n_o.bus = drv.bus & (ctl_bus_n_i | ctl_bus_oe_n_i);
  end
  initial
  begin
    drv         = '1;
    drv.port_en = 1'b0;
    lag         = 0;
  end
  // ------------------------------------------------------------
  // host actions
  // ------------------------------------------------------------
  task automatic port(input logic en_n);
    @(negedge clk_sys_i);
    drv.port_en = en_n;
  endtask
  task automatic gates(input logic wr_n);
    @(negedge clk_sys_i);
    drv.write_gate = wr_n;
  endtask
  task automatic wait_ack(input logic lvl, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 200 && !ok; n++)
    begin
      @(negedge clk_sys_i);
      ok = (ack_n_i === lvl);
    end
  endtask
  task automatic radial(input logic dir_n, input logic [7:0] bits);
    @(negedge clk_sys_i);
    drv.dir_out = dir_n;
    drv.bus     = dir_n ? 8'hff : ~bits;
    drv.strobe  = 1'b0;
    repeat (6) @(negedge clk_sys_i);
  endtask
  task automatic radial_end();
    drv.strobe  = 1'b1;
    drv.bus     = 8'hff;
    drv.dir_out = 1'b1;
    repeat (6) @(negedge clk_sys_i);
  endtask
  // request and byte held until the acknowledge is seen
  task automatic xfer(input logic [7:0] cmd, input logic par_out,
                      input logic [7:0] par, output logic [7:0] got,
                      output logic ok);
    logic ok2;
    @(negedge clk_sys_i);
    drv.dir_out = 1'b0;
    drv.bus     = ~cmd;
    drv.cmd_req = 1'b0;
    wait_ack(1'b0, ok);
    drv.cmd_req = 1'b1;
    drv.bus     = 8'hff;
    wait_ack(1'b1, ok2);
    ok = ok & ok2;
    repeat (lag) @(negedge clk_sys_i);
    drv.dir_out = !par_out;
    drv.bus     = par_out ? ~par : 8'hff;
    drv.par_req = 1'b0;
    wait_ack(1'b0, ok2);
    got         = ~pins_n_o.bus;
    ok          = ok & ok2;
    drv.par_req = 1'b1;
    drv.bus     = 8'hff;
    drv.dir_out = 1'b1;
    wait_ack(1'b1, ok2);
    ok = ok & ok2;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb_disk_drive_control_interface.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_disk_drive_control_interface;
  import ddci_pkg::*;
  logic       clk_sys_i, rst_i, busy_c, err_c, done, ok, fail, attn_oe_n;
  logic [2:0] cmdp;
  logic [1:0] tick, seen;
  logic [7:0] status, got, ctl_bus_n, ctl_bus_oe_n, param_byte, cmd_byte;
  logic       ack_n, busy_n, attn_n, index_n, sector_n, write_en, exec;
  logic       selected, init_state, bus_err, fault;
  ddci_pins_s pins_n;
  int         fails, checked, cyc;

  ddci_device uut (
    .clk_sys_i     (clk_sys_i),
    .rst_i         (rst_i),
    .pins_n_i      (pins_n),
    .busy_cause_i  (busy_c),
    .err_cause_i   (err_c),
    .done_i        (done),
    .fail_i        (fail),
    .status_i      (status),
    .svc_clear_i   (cmdp[0]),
    .fault_clear_i (cmdp[1]),
    .reinit_i      (cmdp[2]),
    .index_tick_i  (tick[0]),
    .sector_tick_i (tick[1]),
    .am_found_i    (1'b0),
    .ctl_bus_n_o   (ctl_bus_n),
    .ctl_bus_oe_n_o(ctl_bus_oe_n),
    .ack_n_o       (ack_n),
    .busy_n_o      (busy_n),
    .attn_n_o      (attn_n),
    .attn_oe_n_o   (attn_oe_n),
    .index_n_o     (index_n),
    .sector_n_o    (sector_n),
    .write_en_o    (write_en),
    .am_write_o    (),
    .exec_o        (exec),
    .cmd_byte_o    (cmd_byte),
    .param_byte_o  (param_byte),
    .selected_o    (selected),
    .init_state_o  (init_state),
    .bus_err_o     (bus_err),
    .fault_o       (fault)
  );
  ddci_host_model host (
    .clk_sys_i     (clk_sys_i),
    .ack_n_i       (ack_n),
    .ctl_bus_n_i   (ctl_bus_n),
    .ctl_bus_oe_n_i(ctl_bus_oe_n),
    .pins_n_o      (pins_n)
  );
  // ------------------------------------------------------------
  // clock, user side, watchdog
  // ------------------------------------------------------------
  initial
  begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  always @(negedge clk_sys_i) done <= exec;
  always @(posedge clk_sys_i)
  begin
    seen <= seen | {~sector_n, ~index_n};
    cyc++;
    if (cyc > 20000)
    begin
      fails++;
      wrap_up();
    end
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got_v);
    checked++;
    if (got_v !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got_v);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic pulse(input int b);
    @(negedge clk_sys_i);
    cmdp[b] = 1'b1;
    @(negedge clk_sys_i);
    cmdp[b] = 1'b0;
    repeat (4) @(negedge clk_sys_i);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    repeat (8) @(negedge clk_sys_i);
    chk("init", 8'h01, init_state);
    chk("sel", 8'h00, selected);
    chk("oe", 8'hff, ctl_bus_oe_n);
    chk("attn", 8'h00, attn_n);
    chk("attn_oe", 8'h00, attn_oe_n);
  endtask
  task automatic t_poll();
    host.radial(1'b1, 8'h00);
    chk("poll", 8'h01, ~pins_n.bus);
    host.radial_end();
    pulse(0);
    chk("attn", 8'h01, attn_n);
    host.radial(1'b1, 8'h00);
    chk("poll", 8'hff, ctl_bus_oe_n);
    host.radial_end();
  endtask
  task automatic t_select();
    host.radial(1'b0, 8'h02);
    chk("sel", 8'h00, selected);
    chk("ack", 8'h01, ack_n);
    host.radial_end();
    host.radial(1'b0, 8'h01);
    chk("sel", 8'h01, selected);
    chk("ack", 8'h00, ack_n);
    host.radial_end();
    chk("ack", 8'h01, ack_n);
    host.radial(1'b0, 8'h00);
    chk("sel", 8'h00, selected);
    host.radial_end();
    host.radial(1'b0, 8'h01);
    host.radial_end();
  endtask
  task automatic t_cmd();
    host.lag = 3;
    host.xfer(CMD_WR_CTRL, 1'b1, 8'h80, got, ok);
    host.lag = 0;
    chk("ok", 8'h01, ok);
    chk("par", 8'h80, param_byte);
    chk("cmd", CMD_WR_CTRL, cmd_byte);
    host.gates(1'b0);
    repeat (4) @(negedge clk_sys_i);
    chk("wen", 8'h01, write_en);
    status = 8'h5a;
    host.xfer(8'h03, 1'b0, 8'h00, got, ok);
    chk("pin", 8'h5a, got);
    chk("err", 8'h00, bus_err);
    host.xfer(8'h44, 1'b0, 8'h00, got, ok);
    chk("ok", 8'h01, ok);
    chk("err", 8'h01, bus_err);
    chk("attn", 8'h00, attn_n);
  endtask
  task automatic t_busy();
    pulse(0);
    busy_c = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    chk("busy", 8'h00, busy_n);
    fork
      host.xfer(8'h03, 1'b0, 8'h00, got, ok);
      begin
        repeat (20) @(negedge clk_sys_i);
        chk("ack", 8'h01, ack_n);
        busy_c = 1'b0;
      end
    join
    chk("ok", 8'h01, ok);
    chk("attn", 8'h00, attn_n);
    pulse(0);
    fail = 1'b1;
    host.xfer(8'h03, 1'b0, 8'h00, got, ok);
    fail = 1'b0;
    chk("ok", 8'h01, ok);
    chk("attn", 8'h00, attn_n);
  endtask
  task automatic t_fault();
    err_c = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    err_c = 1'b0;
    chk("fault", 8'h01, fault);
    pulse(1);
    chk("fault", 8'h00, fault);
  endtask
  task automatic t_ticks();
    seen = 2'b00;
    tick = 2'b11;
    @(negedge clk_sys_i);
    tick = 2'b00;
    repeat (4) @(negedge clk_sys_i);
    chk("idx", 8'h01, seen);
    seen = 2'b00;
    tick = 2'b10;
    @(negedge clk_sys_i);
    tick = 2'b00;
    repeat (4) @(negedge clk_sys_i);
    chk("sec", 8'h02, seen);
  endtask
  task automatic t_port();
    host.port(1'b1);
    repeat (25) @(negedge clk_sys_i);
    chk("wen", 8'h00, write_en);
    chk("sel", 8'h00, selected);
    host.radial(1'b0, 8'h01);
    chk("sel", 8'h00, selected);
    host.radial_end();
    host.port(1'b0);
    repeat (8) @(negedge clk_sys_i);
    chk("init", 8'h01, init_state);
    chk("attn", 8'h00, attn_n);
  endtask
  task automatic t_reinit();
    host.radial(1'b0, 8'h01);
    host.radial_end();
    host.xfer(CMD_WR_CTRL, 1'b1, 8'h80, got, ok);
    chk("wen", 8'h01, write_en);
    pulse(1);
    chk("init", 8'h00, init_state);
    pulse(2);
    chk("init", 8'h01, init_state);
    chk("sel", 8'h00, selected);
    chk("wen", 8'h00, write_en);
  endtask
  initial
  begin
    rst_i = 1'b1;
    {busy_c, err_c, done, fail, cmdp, tick, seen, status} = '0;
    repeat (16) @(negedge clk_sys_i);
    rst_i = 1'b0;
    t_reset();
    t_poll();
    t_select();
    t_cmd();
    t_busy();
    t_fault();
    t_ticks();
    t_port();
    t_reinit();
    wrap_up();
  end
endmodule
`default_nettype wire
